// ---- rtl/ufb_clkdiv.sv ----
// Divide-by-n-and-a-half generator for the UART core clock
`timescale 1ns/1ns
`default_nettype none
module ufb_clkdiv
  import ufb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic restart,
  input wire logic [ufb_pkg::DIV_W-1:0] code,
  output logic tick,
  output logic uart_clk
);
  // ************************************************************
  // Period counter
  // ************************************************************
  // Half divisors alternate periods of n and n+1 reference cycles
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic phase_r;
  logic [DIV_W-1:0] whole;
  logic split;
  logic stopped;
  logic at_end;

  assign whole = code >> 1;
  assign split = code >= DIV_MIN_SPLIT;
  assign stopped = code == DIV_RST;
  assign at_end = cnt_r == DIV_RST;
  assign tick = !stopped && (!split || at_end);
  assign cnt_nxt = whole - DIV_W'(1) + DIV_W'(code[0] & phase_r);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= DIV_RST;
      phase_r <= 1'b0;
      uart_clk <= 1'b1;
    end
    else if (ce)
    begin
      if (restart)
      begin
        cnt_r <= DIV_RST;
        phase_r <= 1'b0;
        uart_clk <= 1'b1;
      end
      else
      begin
        uart_clk <= !(tick && split);
        if (split && at_end)
        begin
          cnt_r <= cnt_nxt;
          phase_r <= !phase_r;
        end
        else if (split)
          cnt_r <= cnt_r - DIV_W'(1);
      end
    end
  end
endmodule // ufb_clkdiv
`default_nettype wire

// ---- rtl/ufb_pkg.sv ----
// Shared constants and carriers for the UART flow, bypass and clock divider block
package ufb_pkg;
  // ************************************************************
  // Subsystem register map
  // ************************************************************
  localparam logic [8:0] SS_CTRL_ADDR = 9'h110;
  localparam logic [8:0] DIVISOR_ADDR = 9'h120;
  localparam logic [8:0] MCR_WR_ADDR = 9'h130;
  localparam logic [8:0] FCR_RD_ADDR = 9'h132;
  localparam logic [8:0] MCR_RD_ADDR = 9'h134;
  localparam logic [8:0] BYPASS_ADDR = 9'h140;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BYPASS_BIT = 7;
  localparam int AUTO_CTS_BIT = 5;
  localparam int RTS_BIT = 1;
  localparam int FCR_AUTO_RTS_BIT = 4;
  localparam int FCR_DEEP_BIT = 5;
  localparam int FCR_TRIG_LO = 6;
  localparam int FCR_FORCED_LO = 1;
  localparam int FCR_FORCED_HI = 2;
  localparam int DIV_W = 6;
  localparam int CNT_W = 7;

  // ************************************************************
  // Reset values and thresholds
  // ************************************************************
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [DIV_W-1:0] DIV_RST = 6'h00;
  localparam logic [DIV_W-1:0] DIV_MIN_SPLIT = 6'h04;
  localparam logic [CNT_W-1:0] RTS_LIMIT_16 = 7'h0E;
  localparam logic [CNT_W-1:0] RTS_LIMIT_64 = 7'h38;
  localparam logic [CNT_W-1:0] TRIG64_0 = 7'h01;
  localparam logic [CNT_W-1:0] TRIG64_1 = 7'h10;
  localparam logic [CNT_W-1:0] TRIG64_2 = 7'h20;
  localparam logic [CNT_W-1:0] TRIG64_3 = 7'h38;
  localparam logic [CNT_W-1:0] TRIG16_0 = 7'h01;
  localparam logic [CNT_W-1:0] TRIG16_1 = 7'h04;
  localparam logic [CNT_W-1:0] TRIG16_2 = 7'h08;
  localparam logic [CNT_W-1:0] TRIG16_3 = 7'h0E;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [8:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ufb_ss_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } ufb_host_wr_t;
endpackage

// ---- rtl/ufb_top.sv ----
// Flow control, serial bypass and clock divider around a 550-style UART core
// Summary of operation
// - Divisor 0 holds clock high; 1..3 divide by one; 4..3F divide by code/2.
// - Bypass bit 7 set: write 140h loads receive FIFO, read unloads transmit FIFO.
// - In bypass, parity, framing and break interrupts are suppressed; others stay.
// - Auto-CTS enabled only by subsystem writing bit 5 at address 130h.
// - Auto-CTS with CTS high: finish current character, start no more.
// - Modem drives CTS low to permit data; transmission then resumes.
// - Auto-CTS leaves all interrupt generation unchanged.
// - Auto-RTS active only with FIFO control bit 4 and extend low; own threshold.
// - 16-byte mode: clear RTS bit at 14 received characters, RTS pin high.
// - 64-byte mode: clear RTS bit at 56 received characters.
// - Data-available interrupt at trigger level, same with or without auto-RTS.
// - Divisor is 6-bit write-only; each write resets UART core and divider.
// - Bypass bit is cleared by reset.
// - Depth is 64 only with bit 5 set and extend low, otherwise 16.
// - 64-byte mode triggers are 1, 16, 32, 56 for codes 00..11.
`timescale 1ns/1ns
`default_nettype none
module ufb_top
  import ufb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire ufb_pkg::ufb_ss_req_t ss_req,
  output logic [7:0] ss_rdata,
  input wire ufb_pkg::ufb_host_wr_t host_mcr_wr,
  input wire ufb_pkg::ufb_host_wr_t host_fcr_wr,
  input wire logic extend,
  input wire logic cts_n,
  output logic rts_n,
  input wire logic [ufb_pkg::CNT_W-1:0] rx_count,
  input wire logic tx_start_req,
  output logic tx_start_ok,
  output logic rx_push,
  output logic [7:0] rx_push_data,
  output logic tx_pop,
  input wire logic [7:0] tx_head_data,
  output logic serial_bypass,
  output logic line_err_int_en,
  output logic rx_avail_int,
  output logic deep_fifo,
  output logic [ufb_pkg::CNT_W-1:0] rx_trigger,
  output logic core_rst,
  output logic uart_tick,
  output logic divided_uart_clock
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] ext_sync_r;
  logic [1:0] cts_sync_r;
  logic ext_lo;
  logic cts_hi;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_sync_r <= 2'h3;
      cts_sync_r <= 2'h3;
    end
    else if (ce)
    begin
      ext_sync_r <= {ext_sync_r[0], extend};
      cts_sync_r <= {cts_sync_r[0], cts_n};
    end
  end

  assign ext_lo = !ext_sync_r[1];
  assign cts_hi = cts_sync_r[1];

  // ************************************************************
  // Address decode
  // ************************************************************
  logic wr_ctrl;
  logic wr_div;
  logic wr_mcr;
  logic wr_byp;
  logic rd_byp;

  assign wr_ctrl = ss_req.wr && ss_req.addr == SS_CTRL_ADDR;
  assign wr_div = ss_req.wr && ss_req.addr == DIVISOR_ADDR;
  assign wr_mcr = ss_req.wr && ss_req.addr == MCR_WR_ADDR;
  assign wr_byp = ss_req.wr && ss_req.addr == BYPASS_ADDR && serial_bypass;
  assign rd_byp = ss_req.rd && ss_req.addr == BYPASS_ADDR && serial_bypass;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [DIV_W-1:0] div_r;
  logic [7:0] mcr_r;
  logic [7:0] mcr_nxt;
  logic [7:0] fcr_r;
  logic auto_cts_r;
  logic auto_rts;
  logic [CNT_W-1:0] rts_limit;
  logic rts_drop;
  logic [7:0] mcr_view;
  logic [7:0] fcr_view;
  logic [7:0] rd_nxt;

  assign auto_rts = fcr_r[FCR_AUTO_RTS_BIT] && ext_lo;
  assign deep_fifo = fcr_r[FCR_DEEP_BIT] && ext_lo;
  assign rts_limit = deep_fifo ? RTS_LIMIT_64 : RTS_LIMIT_16;
  // Separate compare from the trigger path so both can differ
  assign rts_drop = auto_rts && rx_count >= rts_limit;

  // Auto clear outranks a host set so RTS cannot bounce while full
  always_comb
  begin
    mcr_nxt = host_mcr_wr.wr ? host_mcr_wr.data : mcr_r;
    if (rts_drop)
      mcr_nxt[RTS_BIT] = 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      serial_bypass <= 1'b0;
      div_r <= DIV_RST;
      mcr_r <= MCR_RST;
      fcr_r <= FCR_RST;
      auto_cts_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        serial_bypass <= ss_req.wdata[BYPASS_BIT];
      if (wr_div)
        div_r <= ss_req.wdata[DIV_W-1:0];
      if (wr_mcr)
        auto_cts_r <= ss_req.wdata[AUTO_CTS_BIT];
      if (host_fcr_wr.wr)
        fcr_r <= host_fcr_wr.data;
      mcr_r <= mcr_nxt;
    end
  end

  assign rts_n = !mcr_r[RTS_BIT];

  // ************************************************************
  // Read path
  // ************************************************************
  // Divisor is write-only and reads back as zero
  always_comb
  begin
    mcr_view = mcr_r;
    mcr_view[AUTO_CTS_BIT] = auto_cts_r;
    fcr_view = fcr_r;
    fcr_view[FCR_FORCED_LO] = 1'b1;
    fcr_view[FCR_FORCED_HI] = 1'b1;
    fcr_view[FCR_AUTO_RTS_BIT] = !auto_rts;
    fcr_view[FCR_DEEP_BIT] = !deep_fifo;
    rd_nxt = 8'h00;
    if (ss_req.addr == MCR_RD_ADDR)
      rd_nxt = mcr_view;
    else if (ss_req.addr == FCR_RD_ADDR)
      rd_nxt = fcr_view;
    else if (ss_req.addr == SS_CTRL_ADDR)
      rd_nxt = {serial_bypass, 7'h00};
    else if (rd_byp)
      rd_nxt = tx_head_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ss_rdata <= 8'h00;
      rx_push <= 1'b0;
      rx_push_data <= 8'h00;
      tx_pop <= 1'b0;
      core_rst <= 1'b1;
    end
    else if (ce)
    begin
      if (ss_req.rd)
        ss_rdata <= rd_nxt;
      rx_push <= wr_byp;
      if (wr_byp)
        rx_push_data <= ss_req.wdata;
      tx_pop <= rd_byp;
      core_rst <= wr_div;
    end
  end

  // ************************************************************
  // Flow control and interrupt qualifiers
  // ************************************************************
  // Only a new start is gated, so a character in flight completes
  assign tx_start_ok = tx_start_req && !(auto_cts_r && cts_hi);
  assign line_err_int_en = !serial_bypass;
  // No auto-CTS term here keeps interrupts unaffected by it
  assign rx_avail_int = rx_count >= rx_trigger;

  always_comb
  begin
    unique case (fcr_r[FCR_TRIG_LO +: 2])
      2'h0: rx_trigger = deep_fifo ? TRIG64_0 : TRIG16_0;
      2'h1: rx_trigger = deep_fifo ? TRIG64_1 : TRIG16_1;
      2'h2: rx_trigger = deep_fifo ? TRIG64_2 : TRIG16_2;
      2'h3: rx_trigger = deep_fifo ? TRIG64_3 : TRIG16_3;
    endcase
  end

  // ************************************************************
  // Clock divider
  // ************************************************************
  ufb_clkdiv u_div (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .restart(wr_div),
    .code(div_r),
    .tick(uart_tick),
    .uart_clk(divided_uart_clock)
  );
endmodule // ufb_top
`default_nettype wire

// ---- verif/ufb_modem_model.sv ----
// Modem-side stand-in: CTS, receive fill level and transmit head byte
`timescale 1ns/1ns
`default_nettype none
module ufb_modem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic hold_off,
  input wire logic [6:0] fill,
  input wire logic tx_pop,
  output logic cts_n,
  output logic [6:0] rx_count,
  output logic [7:0] tx_head_data
);
  assign cts_n = hold_off;
  assign rx_count = fill;
  // Head byte steps on each pop, so a stale read shows
  always_ff @(negedge clk or posedge rst)
    if (rst)
      tx_head_data <= 8'h3C;
    else if (tx_pop)
      tx_head_data <= tx_head_data + 8'h01;
endmodule // ufb_modem_model
`default_nettype wire

// ---- verif/ufb_top_asserts.sv ----
// Port checker for the flow, bypass and divider block
`timescale 1ns/1ns
`default_nettype none
module ufb_top_asserts
  import ufb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire ufb_pkg::ufb_ss_req_t ss_req,
  input wire logic [7:0] ss_rdata,
  input wire logic [7:0] tx_head_data,
  input wire logic tx_start_req,
  input wire logic tx_start_ok,
  input wire logic rx_push,
  input wire logic [7:0] rx_push_data,
  input wire logic tx_pop,
  input wire logic serial_bypass,
  input wire logic line_err_int_en,
  input wire logic deep_fifo,
  input wire logic [ufb_pkg::CNT_W-1:0] rx_trigger,
  input wire logic core_rst,
  input wire logic uart_tick,
  input wire logic divided_uart_clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic deep_level;
  // Frozen cycles are skipped, as the pulses then hold
  assign deep_level = rx_trigger inside {TRIG64_0, TRIG64_1, TRIG64_2, TRIG64_3};
  sequence byp_rd_s;
    ce && ss_req.rd && ss_req.addr == BYPASS_ADDR && serial_bypass;
  endsequence
  sequence pop_s;
    tx_pop && ss_rdata == $past(tx_head_data)
    ##1 (!$past(ce)
      || tx_pop == $past(ss_req.rd && ss_req.addr == BYPASS_ADDR && serial_bypass));
  endsequence
  sequence byp_wr_s;
    ce && ss_req.wr && ss_req.addr == BYPASS_ADDR && serial_bypass;
  endsequence
  sequence push_s;
    rx_push && rx_push_data == $past(ss_req.wdata);
  endsequence
  sequence div_wr_s;
    ce && ss_req.wr && ss_req.addr == DIVISOR_ADDR;
  endsequence
  bypass_read_a: assert property (byp_rd_s |=> pop_s)
    else $error("bypass read did not pop once");
  bypass_write_a: assert property (byp_wr_s |=> push_s)
    else $error("bypass push lost");
  push_gate_a: assert property (rx_push |-> $past(serial_bypass))
    else $error("push without bypass");
  line_err_a: assert property (line_err_int_en == !serial_bypass)
    else $error("line error enable wrong");
  cts_gate_a: assert property (tx_start_ok |-> tx_start_req)
    else $error("start granted unasked");
  deep_trig_a: assert property (deep_fifo |-> deep_level)
    else $error("deep trigger level wrong");
  div_reset_a: assert property (div_wr_s |=> core_rst)
    else $error("divisor write without core reset");
  clk_low_a: assert property (!divided_uart_clock |-> $past(uart_tick))
    else $error("clock low without tick");
endmodule // ufb_top_asserts
bind ufb_top ufb_top_asserts u_ufb_top_asserts (.clk, .rst, .ce, .ss_req, .ss_rdata,
  .tx_head_data, .tx_start_req, .tx_start_ok, .rx_push, .rx_push_data, .tx_pop,
  .serial_bypass, .line_err_int_en, .deep_fifo, .rx_trigger, .core_rst, .uart_tick,
  .divided_uart_clock);
`default_nettype wire

// ---- verif/ufb_top_tb_top.sv ----
// Directed bench for the flow, bypass and divider block
`timescale 1ns/1ns
`default_nettype none
module ufb_top_tb_top;
  import ufb_pkg::*;
  logic clk = 0, rst = 1, ce = 1, extend = 0, tx_start_req = 0, hold_off = 0;
  ufb_ss_req_t ss_req = '0;
  ufb_host_wr_t mcr_w = '0, fcr_w = '0;
  logic [6:0] fill = '0, rx_count, rx_trigger;
  logic [7:0] rdata, ev, pd, ss_rdata, rx_push_data, tx_head_data;
  logic cts_n, rts_n, tx_start_ok, rx_push, tx_pop, serial_bypass, line_err_int_en;
  logic rx_avail_int, deep_fifo, core_rst, uart_tick, divided_uart_clock;
  logic [6:0] trig [4] = '{TRIG64_0, TRIG64_1, TRIG64_2, TRIG64_3};
  int failures = 0, n_tests = 0;
  always #50 clk = ~clk;
  ufb_top u_ufb_top (.clk, .rst, .ce, .ss_req, .ss_rdata, .host_mcr_wr(mcr_w),
    .host_fcr_wr(fcr_w), .extend, .cts_n, .rts_n, .rx_count, .tx_start_req, .tx_start_ok,
    .rx_push, .rx_push_data, .tx_pop, .tx_head_data, .serial_bypass, .line_err_int_en,
    .rx_avail_int, .deep_fifo, .rx_trigger, .core_rst, .uart_tick, .divided_uart_clock);
  ufb_modem_model u_ufb_modem_model (.clk, .rst, .hold_off, .fill, .tx_pop, .cts_n,
    .rx_count, .tx_head_data);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Subsystem access; pulses are caught in the cycle they stand
  task automatic ss(input logic [8:0] a, input logic w, input logic [7:0] d);
    ss_req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge clk);
    rdata = ss_rdata;
    ev = {5'h00, rx_push, tx_pop, core_rst};
    pd = rx_push_data;
    ss_req = '0;
    @(negedge clk);
  endtask
  task automatic hw(input logic m, input logic [7:0] d);
    if (m)
      mcr_w = '{1'b1, d};
    else
      fcr_w = '{1'b1, d};
    @(negedge clk);
    mcr_w = '0;
    fcr_w = '0;
    @(negedge clk);
  endtask
  // Full-period windows, so the count is independent of phase
  task automatic ticks(input logic [7:0] code, input int n, input logic [7:0] exp);
    logic [7:0] t, lo;
    t = 0;
    lo = 0;
    ss(DIVISOR_ADDR, 1, code);
    chk(ev, 8'h01);
    repeat (n)
    begin
      @(negedge clk);
      t += uart_tick;
      lo += !divided_uart_clock;
    end
    chk(t, exp);
    chk(lo, (code < 8'h04) ? 8'h00 : exp);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    cyc(20);
    rst = 0;
    cyc(2);
    ss(BYPASS_ADDR, 1, 8'hA5);
    chk(ev, 8'h00);
    ss(SS_CTRL_ADDR, 1, 8'h80);
    chk(line_err_int_en, 8'h00);
    chk(serial_bypass, 8'h01);
    ss(BYPASS_ADDR, 1, 8'hA5);
    chk(ev, 8'h04);
    chk(pd, 8'hA5);
    ss(BYPASS_ADDR, 0, 8'h00);
    chk(ev, 8'h02);
    chk(rdata, 8'h3C);
    ss(BYPASS_ADDR, 0, 8'h00);
    chk(rdata, 8'h3D);
    tx_start_req = 1;
    hold_off = 1;
    cyc(3);
    chk(tx_start_ok, 8'h01);
    ss(MCR_WR_ADDR, 1, 8'h20);
    chk(tx_start_ok, 8'h00);
    hold_off = 0;
    cyc(3);
    chk(tx_start_ok, 8'h01);
    ss(MCR_RD_ADDR, 0, 8'h00);
    chk(rdata, 8'h20);
    hw(1, 8'h02);
    hw(0, 8'h10);
    fill = 7'd13;
    cyc(2);
    chk(rts_n, 8'h00);
    fill = 7'd14;
    cyc(2);
    chk(rts_n, 8'h01);
    ss(FCR_RD_ADDR, 0, 8'h00);
    chk(rdata, 8'h26);
    fill = 7'd0;
    hw(1, 8'h02);
    chk(rts_n, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      hw(0, {i[1:0], 6'h30});
      chk(rx_trigger, trig[i]);
    end
    chk(deep_fifo, 8'h01);
    fill = 7'd55;
    cyc(2);
    chk(rts_n, 8'h00);
    chk(rx_avail_int, 8'h00);
    fill = 7'd56;
    cyc(2);
    chk(rts_n, 8'h01);
    chk(rx_avail_int, 8'h01);
    extend = 1;
    cyc(3);
    chk(deep_fifo, 8'h00);
    chk(rx_avail_int, 8'h01);
    ticks(8'h00, 20, 8'h00);
    ticks(8'h02, 20, 8'd20);
    ticks(8'h08, 40, 8'd10);
    ticks(8'h09, 36, 8'd8);
    rst = 1;
    cyc(2);
    rst = 0;
    cyc(2);
    // Write while frozen must not land
    ce = 0;
    ss(SS_CTRL_ADDR, 1, 8'h80);
    ce = 1;
    chk(serial_bypass, 8'h00);
    ss(SS_CTRL_ADDR, 0, 8'h00);
    chk(rdata, 8'h00);
    chk(line_err_int_en, 8'h01);
    give_verdict();
  end
endmodule // ufb_top_tb_top
`default_nettype wire
